// ---- src/rcs_calendar.sv ----
`timescale 1ns/1ps
module rcs_calendar (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // one-second tick from the rtc oscillator divider
    input wire logic sec_tick,
    // register access
    input wire rcs_pkg::rcs_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // status
    output logic clock_running
);
    rcs_pkg::rcs_cal_t live;
    rcs_pkg::rcs_cal_t next_live;
    rcs_pkg::rcs_cal_t stage;
    rcs_pkg::rcs_cal_t snap;
    logic commit;

    assign commit = req.wr && (req.addr == rcs_pkg::ADDR_YEAR);

    // years 2000..2063 leap every fourth, 2000 included
    function automatic logic [4:0] month_days(input logic [3:0] m, input logic [5:0] y);
        logic [4:0] d;
        d = 5'h1F;
        unique case (m)
            4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
            4'h2: d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            default: d = 5'h1F;
        endcase
        return d;
    endfunction : month_days

    always_comb begin
        next_live = live;
        if (live.sec >= rcs_pkg::SEC_MAX) begin
            next_live.sec = 6'h00;
            if (live.min >= rcs_pkg::MIN_MAX) begin
                next_live.min = 6'h00;
                if (live.hour >= rcs_pkg::HOUR_MAX) begin
                    next_live.hour = 5'h00;
                    if (live.day >= month_days(live.month, live.year)) begin
                        next_live.day = 5'h01;
                        if (live.month >= rcs_pkg::MONTH_MAX) begin
                            next_live.month = 4'h1;
                            next_live.year = 6'(live.year + 6'h01);
                        end else begin
                            next_live.month = 4'(live.month + 4'h1);
                        end
                    end else begin
                        next_live.day = 5'(live.day + 5'h01);
                    end
                end else begin
                    next_live.hour = 5'(live.hour + 5'h01);
                end
            end else begin
                next_live.min = 6'(live.min + 6'h01);
            end
        end else begin
            next_live.sec = 6'(live.sec + 6'h01);
        end
    end

    // running calendar; a commit beats a tick in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            live <= rcs_pkg::RST_CAL;
        end else if (commit) begin
            live <= '{stage.sec, stage.min, stage.hour, stage.day, stage.month,
                      req.wdata[5:0]};
        end else if (sec_tick && clock_running) begin
            live <= next_live;
        end
    end

    // clock stays stopped until software sets the calendar once
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_running <= 1'b0;
        end else if (commit) begin
            clock_running <= 1'b1;
        end
    end

    // staging; only the field bits are kept
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage <= rcs_pkg::RST_CAL;
        end else if (req.wr) begin
            unique case (req.addr)
                rcs_pkg::ADDR_SECONDS: stage.sec <= req.wdata[5:0];
                rcs_pkg::ADDR_MINUTES: stage.min <= req.wdata[5:0];
                rcs_pkg::ADDR_HOURS: stage.hour <= req.wdata[4:0];
                rcs_pkg::ADDR_DAY: stage.day <= req.wdata[4:0];
                rcs_pkg::ADDR_MONTH: stage.month <= req.wdata[3:0];
                rcs_pkg::ADDR_YEAR: stage.year <= req.wdata[5:0];
                default: stage <= stage;
            endcase
        end
    end

    // snapshot, so multi-byte reads never tear across a carry
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            snap <= rcs_pkg::RST_CAL;
        end else if (req.rd && (req.addr == rcs_pkg::ADDR_SECONDS)) begin
            snap <= live;
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            rdata <= 8'h00;
            if (req.rd) begin
                unique case (req.addr)
                    rcs_pkg::ADDR_SECONDS: begin
                        rdata[rcs_pkg::READY_BIT] <= clock_running;
                        rdata[5:0] <= live.sec;
                    end
                    rcs_pkg::ADDR_MINUTES: rdata[5:0] <= snap.min;
                    rcs_pkg::ADDR_HOURS: rdata[4:0] <= snap.hour;
                    rcs_pkg::ADDR_DAY: rdata[4:0] <= snap.day;
                    rcs_pkg::ADDR_MONTH: rdata[3:0] <= snap.month;
                    rcs_pkg::ADDR_YEAR: rdata[5:0] <= snap.year;
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule : rcs_calendar

// ---- include/rcs_pkg.sv ----
// Summary of operation
// - seconds register top bit flags calendar ready
// - field writes staged until year write commits
// - seconds read copies live calendar into snapshot
// - other field reads return last snapshot values
// - minutes six bits, counting zero to fifty-nine
// - month four bits, one to twelve
// - year write starts clock, commits staged fields
// - year also captured by seconds read snapshot
package rcs_pkg;
    localparam logic [7:0] ADDR_SECONDS = 8'h40;
    localparam logic [7:0] ADDR_MINUTES = 8'h41;
    localparam logic [7:0] ADDR_HOURS = 8'h42;
    localparam logic [7:0] ADDR_DAY = 8'h43;
    localparam logic [7:0] ADDR_MONTH = 8'h44;
    localparam logic [7:0] ADDR_YEAR = 8'h45;
    localparam int READY_BIT = 7;
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [5:0] RST_SEC = 6'h00;
    localparam logic [5:0] RST_MIN = 6'h00;
    localparam logic [4:0] RST_HOUR = 5'h00;
    localparam logic [4:0] RST_DAY = 5'h01;
    localparam logic [3:0] RST_MONTH = 4'h1;
    localparam logic [5:0] RST_YEAR = 6'h00;

    typedef struct packed {
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hour;
        logic [4:0] day;
        logic [3:0] month;
        logic [5:0] year;
    } rcs_cal_t;

    localparam rcs_cal_t RST_CAL = '{RST_SEC, RST_MIN, RST_HOUR, RST_DAY, RST_MONTH, RST_YEAR};

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcs_req_t;
endpackage : rcs_pkg

// ---- tb/rcs_host.sv ----
`timescale 1ns/1ps
module rcs_host (
    // bus
    input wire logic sys_clk,
    output rcs_pkg::rcs_req_t req
);
    // strobe lasts one edge, so an access is never taken twice
    initial req = '0;
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge sys_clk) req = '{~w, w, a, d};
        @(negedge sys_clk) req = '0;
    endtask : acc
endmodule : rcs_host

// ---- tb/rcs_calendar_assertions.sv ----
`timescale 1ns/1ps
module rcs_checker (
    // watched ports
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire rcs_pkg::rcs_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic clock_running
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_rd(a);
        req.rd && req.addr == a;
    endsequence
    AST_ANSWER: assert property (req.rd |=> rvalid) else $error("no answer");
    AST_QUIET: assert property (!req.rd |=> !rvalid && rdata == 8'h00) else $error("idle");
    AST_READY: assert property (s_rd(8'h40) |=> rdata[7:6] == {clock_running, 1'b0})
        else $error("ready");
    AST_MIN: assert property (s_rd(8'h41) |=> rdata <= 8'h3B) else $error("min");
    AST_HOUR: assert property (s_rd(8'h42) |=> rdata <= 8'h17) else $error("hour");
    AST_DAY: assert property (s_rd(8'h43) |=> rdata inside {[8'h01:8'h1F]})
        else $error("day");
    AST_MONTH: assert property (s_rd(8'h44) |=> rdata inside {[8'h01:8'h0C]})
        else $error("month");
    AST_START: assert property (req.wr && req.addr == 8'h45 |=> clock_running)
        else $error("start");
    AST_HOLD: assert property (clock_running |=> clock_running) else $error("stopped");
endmodule : rcs_checker
bind rcs_calendar rcs_checker chk_i (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .clock_running(clock_running));

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic sys_clk = 0, arst_n = 0, sec_tick = 0, rvalid, clock_running;
    logic [7:0] rdata;
    logic [5:0] e [6];
    rcs_pkg::rcs_req_t req;
    int fails = 0, num_checks = 0, cyc = 0;
    initial forever #5 sys_clk = ~sys_clk;
    rcs_calendar uut (.sys_clk(sys_clk), .arst_n(arst_n), .sec_tick(sec_tick), .req(req),
        .rdata(rdata), .rvalid(rvalid), .clock_running(clock_running));
    rcs_host host (.sys_clk(sys_clk), .req(req));
    task automatic report_and_stop;
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] a, x);
        host.acc(1'b0, a, 8'h00);
        num_checks++;
        if (rdata !== x) begin
            fails++;
            $display("wrong value %0t: %h, expected %h", $time, rdata, x);
        end
    endtask : chk
    task automatic tick;
        @(negedge sys_clk) sec_tick = 1'b1;
        @(negedge sys_clk) sec_tick = 1'b0;
    endtask : tick
    function automatic logic [7:0] nx(input logic [5:0] m);
        return (m == 6'h3B) ? 8'h00 : {2'h0, m + 6'h01};
    endfunction : nx
    always @(posedge sys_clk) if (++cyc == 900) begin
        fails++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hf008700f));
        e = '{6'h3B, 6'($urandom % 59), 6'($urandom % 24), 6'(1 + $urandom % 31),
            6'(1 + $urandom % 12), 6'($urandom % 64)};
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        tick();
        chk(8'h40, 8'h00);
        for (int i = 0; i < 5; i++) host.acc(1'b1, 8'(8'h40 + i), {2'h2, e[i]});
        chk(8'h40, 8'h00);
        host.acc(1'b1, 8'h45, {2'h2, e[5]});
        chk(8'h40, 8'hBB);
        for (int i = 1; i < 6; i++) chk(8'(8'h40 + i), {2'h0, e[i]});
        tick();
        chk(8'h41, {2'h0, e[1]});
        chk(8'h40, 8'h80);
        chk(8'h41, nx(e[1]));
        chk(8'h50, 8'h00);
        // corner case: last second of a year rolls every field over at once
        e = '{6'h3B, 6'h3B, 6'h17, 6'h1F, 6'h0C, e[5]};
        for (int i = 0; i < 5; i++) host.acc(1'b1, 8'(8'h40 + i), {2'h0, e[i]});
        host.acc(1'b1, 8'h45, {2'h0, e[5]});
        tick();
        chk(8'h40, 8'h80);
        chk(8'h41, 8'h00);
        chk(8'h42, 8'h00);
        chk(8'h43, 8'h01);
        chk(8'h44, 8'h01);
        chk(8'h45, {2'h0, 6'(e[5] + 6'h01)});
        report_and_stop();
    end
endmodule : tb
